// [design/cfl_params.svh]
// Purpose: Constants for the converter fault latch and error log controller.
// Assumes: 100 MHz aclk.
// Notes: Offsets are byte addresses on the register bus.
`ifndef CFL_PARAMS_SVH
`define CFL_PARAMS_SVH
// ****************************************
// Register map
// ****************************************
`define CFL_A_PRE_TIME 8'h00
`define CFL_A_STATUS 8'h04
`define CFL_A_LOG_VIEW 8'h08
`define CFL_A_IRQ_STAT 8'h0c
`define CFL_A_IRQ_EN 8'h10
`define CFL_A_IRQ_CLR 8'h14
`define CFL_A_PARAM 8'h18
`define CFL_PRE_TIME_RST 16'h0bb8
`define CFL_RESP_OKAY 2'h0
`define CFL_RESP_SLVERR 2'h2
// ****************************************
// Timing
// ****************************************
`define CFL_CLK_NS 10
`define CFL_MS_NS 1000000
`define CFL_MS_CYCLES (`CFL_MS_NS / `CFL_CLK_NS)
`define CFL_FLASH_MS 8'hf9
// ****************************************
// Sequence and key input bits, log depth and interrupt bits
// ****************************************
`define CFL_IN_RUN 0
`define CFL_IN_RST 1
`define CFL_IN_CLR 2
`define CFL_IN_MENU 3
`define CFL_IN_UP 4
`define CFL_IN_DN 5
`define CFL_IN_LOG 6
`define CFL_LOG_DEPTH 4'ha
`define CFL_LOG_LAST 4'h9
`define CFL_IRQ_FAULT 0
`define CFL_IRQ_FULL 1
`define CFL_IRQ_RUN 2
`endif

// [design/cfl_pkg.sv]
// Purpose: Types for the converter fault latch and error log controller.
// Assumes: Nothing beyond the constants header.
// Notes: State records are packed so that one flop bank holds them.
package cfl_pkg;
   typedef enum logic [1:0] {RUN_STOPPED, RUN_PRECHARGE, RUN_ACTIVE, RUN_DISCHARGE} cfl_run_t;
   typedef enum logic [1:0] {PANEL_STATUS, PANEL_PROG, PANEL_LOG} cfl_panel_t;
   typedef enum logic [1:0] {DISP_RUN, DISP_ERROR, DISP_BANNER, DISP_LOG} cfl_disp_t;
   typedef struct packed {
      logic [9:0][2:0] entry;
      logic [3:0] count;
      logic [2:0] rd_code;
   } cfl_log_state_t;
endpackage : cfl_pkg

// [design/cfl_log_mem.sv]
// Purpose: Ten-entry error log, oldest entry at index 0.
// Assumes: por_n is asserted only when the backing store is first powered.
// Notes: aresetn of the controller does not touch this store.
`timescale 1ns/1ps
`default_nettype none
`include "cfl_params.svh"
module cfl_log_mem
   import cfl_pkg::*;
(
   // Clock and storage power-on reset
   input wire logic aclk,
   input wire logic por_n,
   // Commands
   input wire logic append,
   input wire logic [2:0] append_code,
   input wire logic clear,
   input wire logic [3:0] rd_idx,
   // Contents
   output logic [2:0] rd_code,
   output logic [3:0] count,
   output logic full
);
   cfl_log_state_t r;
   cfl_log_state_t n;
   logic [3:0] base;

   // ****************************************
   // Storage
   // ****************************************
   // The store is kept apart from the controller reset so that it behaves as retained memory.
   always_comb begin
      n = r;
      base = clear ? 4'h0 : r.count;
      n.count = base;
      if (append && base < `CFL_LOG_DEPTH) begin
         n.entry[base] = append_code;
         n.count = base + 4'h1;
      end
      n.rd_code = (rd_idx < `CFL_LOG_DEPTH) ? r.entry[rd_idx] : 3'h0;
   end

   always_ff @(posedge aclk) begin
      if (!por_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rd_code = r.rd_code;
   assign count = r.count;
   assign full = (r.count == `CFL_LOG_DEPTH);

   // ****************************************
   // Checks
   // ****************************************
   log_full_hold_a: assert property (@(posedge aclk) disable iff (!por_n)
      full && !clear |=> count == `CFL_LOG_DEPTH)
      else $error("log grew past ten entries");
   log_append_a: assert property (@(posedge aclk) disable iff (!por_n)
      append && !full && !clear |=> count == $past(count) + 4'h1 && r.entry[$past(count)] == $past(append_code))
      else $error("log append lost");
   log_clear_a: assert property (@(posedge aclk) disable iff (!por_n)
      clear |=> count == {3'h0, $past(append)})
      else $error("log clear did not empty the store");
endmodule : cfl_log_mem
`default_nettype wire

// [design/cfl_ctrl.sv]
// Purpose: Fault latch, run sequencing, display and error log control of a power converter.
// Assumes: fault_in and bus_ok come from aclk logic; sequence and key inputs are asynchronous pins.
// Notes: Register bus is AXI4-Lite with 32-bit data.
`timescale 1ns/1ps
`default_nettype none
`include "cfl_params.svh"
module cfl_ctrl
   import cfl_pkg::*;
#(
   parameter int MS_CYCLES = `CFL_MS_CYCLES
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic log_por_n,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sequence inputs and panel keys (asynchronous)
   input wire logic run_req,
   input wire logic reset_req,
   input wire logic key_clear,
   input wire logic parameter_menu_key,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic key_log,
   // Converter side
   input wire logic [6:0] fault_in,
   input wire logic bus_ok,
   output logic pwm_enable,
   output logic precharge_en,
   output logic discharge_en,
   output logic param_edit_ok,
   // Display
   output cfl_disp_t disp_sel,
   output logic [2:0] disp_code,
   output logic [3:0] disp_index,
   output logic disp_lit,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic [6:0] sync1, sync2, prev;
      cfl_run_t run_st;
      logic [15:0] timer;
      logic [16:0] ms_cnt;
      logic [7:0] flash_cnt;
      logic flash;
      logic [7:0] err, pend;
      logic [2:0] scroll;
      cfl_panel_t panel;
      logic [3:0] view;
      logic [15:0] pre_time, param;
      logic [2:0] irq_st, irq_en;
      logic aw_ok, w_ok, bvalid, rvalid;
      logic [7:0] awaddr;
      logic [31:0] wdata, rdata;
      logic [1:0] bresp;
      logic pwm, pre, dis;
      cfl_disp_t disp;
      logic [2:0] dcode;
      logic prev_full;
   } cfl_ctrl_state_t;

   cfl_ctrl_state_t r;
   cfl_ctrl_state_t n;
   logic [6:0] rise;
   logic run, ms_tick, timeout, pre_fault, err_clr, log_app, log_clr, wr_fire, rd_fire;
   logic [7:0] new_f;
   logic [2:0] app_code, log_rd;
   logic [3:0] log_count;
   logic log_full;

   function automatic logic [2:0] cfl_next_set(input logic [7:0] mask, input logic [2:0] cur);
      logic [2:0] idx;
      idx = cur;
      for (int i = 8; i >= 1; i--) begin
         if (mask[3'(cur + 3'(i))]) begin
            idx = 3'(cur + 3'(i));
         end
      end
      return idx;
   endfunction : cfl_next_set

   // ****************************************
   // Error log store
   // ****************************************
   cfl_log_mem u_log (
      .aclk(aclk),
      .por_n(log_por_n),
      .append(log_app),
      .append_code(app_code),
      .clear(log_clr),
      .rd_idx(n.view),
      .rd_code(log_rd),
      .count(log_count),
      .full(log_full)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n = r;
      n.sync1 = {key_log, key_down, key_up, parameter_menu_key, key_clear, reset_req, run_req};
      n.sync2 = r.sync1;
      n.prev = r.sync2;
      rise = r.sync2 & ~r.prev;
      run = r.sync2[`CFL_IN_RUN];
      ms_tick = (r.ms_cnt == 17'(MS_CYCLES - 1));
      n.ms_cnt = ms_tick ? 17'h0 : r.ms_cnt + 17'h1;
      // Flash half period counts milliseconds so the one long divider serves every slow timer.
      n.flash_cnt = r.flash_cnt;
      if (ms_tick) begin
         n.flash_cnt = (r.flash_cnt == `CFL_FLASH_MS) ? 8'h0 : r.flash_cnt + 8'h1;
         if (r.flash_cnt == `CFL_FLASH_MS) begin
            n.flash = !r.flash;
         end
      end
      timeout = (r.timer >= r.pre_time);
      pre_fault = (r.run_st == RUN_PRECHARGE) && timeout && !bus_ok;
      new_f = {fault_in, pre_fault};
      err_clr = (rise[`CFL_IN_RST] || (rise[`CFL_IN_CLR] && r.panel != PANEL_LOG)) && !run;
      // A fault in the clearing cycle survives the clear.
      n.err = (err_clr ? 8'h0 : r.err) | new_f;
      // Simultaneous faults queue and enter the log one per cycle.
      log_app = |r.pend;
      app_code = cfl_next_set(r.pend, 3'h7);
      n.pend = (r.pend & ~(8'h1 << app_code)) | (new_f & ~r.err);
      // ****************************************
      // Run sequence
      // ****************************************
      n.timer = (ms_tick && !timeout) ? r.timer + 16'h1 : r.timer;
      unique case (r.run_st)
         RUN_STOPPED: begin
            n.timer = 16'h0;
            if (run && !(|r.err) && !(|new_f)) begin
               n.run_st = RUN_PRECHARGE;
            end
         end
         RUN_PRECHARGE, RUN_ACTIVE: begin
            if (|new_f || |r.err || !run) begin
               n.run_st = RUN_DISCHARGE;
               n.timer = 16'h0;
            end else if (r.run_st == RUN_PRECHARGE && bus_ok) begin
               n.run_st = RUN_ACTIVE;
            end
         end
         RUN_DISCHARGE: begin
            if (timeout) begin
               n.run_st = RUN_STOPPED;
            end
         end
      endcase
      n.pwm = (n.run_st == RUN_ACTIVE);
      n.pre = (n.run_st == RUN_PRECHARGE);
      n.dis = (n.run_st == RUN_DISCHARGE);
      // ****************************************
      // Panel and display
      // ****************************************
      log_clr = 1'b0;
      unique case (r.panel)
         PANEL_STATUS: begin
            if (rise[`CFL_IN_MENU]) begin
               n.panel = PANEL_PROG;
            end else if (rise[`CFL_IN_LOG]) begin
               n.panel = PANEL_LOG;
               n.view = (log_count == 4'h0) ? 4'h0 : log_count - 4'h1;
            end
         end
         PANEL_PROG: begin
            if (rise[`CFL_IN_MENU]) begin
               n.panel = PANEL_STATUS;
            end
         end
         PANEL_LOG: begin
            if (rise[`CFL_IN_UP] && r.view + 4'h1 < log_count) begin
               n.view = r.view + 4'h1;
            end else if (rise[`CFL_IN_DN] && r.view != 4'h0) begin
               n.view = r.view - 4'h1;
            end else if (rise[`CFL_IN_CLR]) begin
               log_clr = 1'b1;
               n.view = 4'h0;
            end else if (rise[`CFL_IN_LOG]) begin
               n.panel = PANEL_STATUS;
            end
         end
         default: begin
            n.panel = PANEL_STATUS;
         end
      endcase
      if (|r.err && ms_tick && r.flash_cnt == `CFL_FLASH_MS && !r.flash) begin
         n.scroll = cfl_next_set(r.err, r.scroll);
      end else if (|r.err && !r.err[r.scroll]) begin
         n.scroll = cfl_next_set(r.err, r.scroll);
      end
      n.disp = (n.panel == PANEL_LOG) ? DISP_LOG : (n.panel == PANEL_PROG) ? DISP_BANNER :
               (|n.err) ? DISP_ERROR : DISP_RUN;
      n.dcode = (n.disp == DISP_ERROR) ? n.scroll : 3'h0;
      // ****************************************
      // Register bus
      // ****************************************
      if (s_axi_awvalid && !r.aw_ok && !r.bvalid) begin
         n.aw_ok = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_ok && !r.bvalid) begin
         n.w_ok = 1'b1;
         n.wdata = s_axi_wdata;
      end
      wr_fire = r.aw_ok && r.w_ok && !r.bvalid;
      n.irq_st = r.irq_st;
      if (wr_fire) begin
         n.aw_ok = 1'b0;
         n.w_ok = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `CFL_RESP_OKAY;
         unique case ({r.awaddr[7:2], 2'h0})
            `CFL_A_PRE_TIME: n.pre_time = r.wdata[15:0];
            `CFL_A_IRQ_EN: n.irq_en = r.wdata[2:0];
            `CFL_A_IRQ_CLR: n.irq_st = r.irq_st & ~r.wdata[2:0];
            `CFL_A_PARAM: begin
               if (|r.err) begin
                  n.bresp = `CFL_RESP_SLVERR;
               end else begin
                  n.param = r.wdata[15:0];
               end
            end
            `CFL_A_STATUS, `CFL_A_LOG_VIEW, `CFL_A_IRQ_STAT: n.bresp = `CFL_RESP_OKAY;
            default: n.bresp = `CFL_RESP_SLVERR;
         endcase
      end else if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      // Event bits are set after the clear so a coincident event is kept.
      n.irq_st = n.irq_st | {n.pwm && !r.pwm, log_full && !r.prev_full, |(new_f & ~r.err)};
      n.prev_full = log_full;
      rd_fire = s_axi_arvalid && !r.rvalid;
      if (rd_fire) begin
         n.rvalid = 1'b1;
         n.rdata = 32'h0;
         unique case ({s_axi_araddr[7:2], 2'h0})
            `CFL_A_PRE_TIME: n.rdata[15:0] = r.pre_time;
            `CFL_A_STATUS: n.rdata[15:0] = {r.panel, log_count, r.run_st, r.err};
            `CFL_A_LOG_VIEW: n.rdata[6:0] = {r.view, log_rd};
            `CFL_A_IRQ_STAT: n.rdata[2:0] = r.irq_st;
            `CFL_A_IRQ_EN: n.rdata[2:0] = r.irq_en;
            `CFL_A_PARAM: n.rdata[15:0] = r.param;
            default: n.rdata = 32'h0;
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.pre_time <= `CFL_PRE_TIME_RST;
         // Starting as full keeps a retained full log from raising a false event after reset.
         r.prev_full <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready = !r.aw_ok && !r.bvalid;
   assign s_axi_wready = !r.w_ok && !r.bvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = `CFL_RESP_OKAY;
   assign pwm_enable = r.pwm;
   assign precharge_en = r.pre;
   assign discharge_en = r.dis;
   assign param_edit_ok = !(|r.err);
   assign disp_sel = r.disp;
   assign disp_code = (r.disp == DISP_LOG) ? log_rd : r.dcode;
   assign disp_index = r.view;
   assign disp_lit = (r.disp == DISP_ERROR) ? r.flash : 1'b1;
   assign irq = |(r.irq_st & r.irq_en);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   no_start_err_a: assert property (r.run_st == RUN_STOPPED && |r.err |=> !r.pre && !r.pwm)
      else $error("start while error latched");
   fault_halt_a: assert property (r.pwm && |new_f |=> !pwm_enable ##0 discharge_en)
      else $error("switching kept after fault");
   reset_run_a: assert property (run && |r.err |=> |r.err)
      else $error("error cleared while run held");
   err_disp_a: assert property (|r.err && r.panel == PANEL_STATUS && !err_clr && !rise[`CFL_IN_MENU]
      && !rise[`CFL_IN_LOG] |=> disp_sel == DISP_ERROR)
      else $error("latched error not shown");
   scroll_pick_a: assert property ($changed(r.scroll) && !$past(err_clr) && |r.err |-> r.err[r.scroll])
      else $error("scroll shows a code that is not latched");
   param_reject_a: assert property (wr_fire && r.awaddr == `CFL_A_PARAM && |r.err
      |=> s_axi_bresp == `CFL_RESP_SLVERR && $stable(r.param))
      else $error("parameter written with error latched");
   banner_a: assert property (r.panel == PANEL_STATUS && rise[`CFL_IN_MENU] |=> disp_sel == DISP_BANNER)
      else $error("program key did not show banner");
   view_newest_a: assert property (r.panel == PANEL_STATUS && !rise[`CFL_IN_MENU] && rise[`CFL_IN_LOG]
      && log_count != 4'h0 |=> disp_index == $past(log_count) - 4'h1)
      else $error("log view did not start at newest");
   view_step_a: assert property (r.panel == PANEL_LOG && rise[`CFL_IN_UP] && r.view + 4'h1 < log_count
      |=> disp_index == $past(r.view) + 4'h1)
      else $error("up key did not step");
   pre_fault_a: assert property (pre_fault |=> r.err[0] ##1 !precharge_en)
      else $error("precharge timeout not latched");
   run_cov_c: cover property (r.pre ##[1:50] r.pwm);
   fault_cov_c: cover property (r.pwm ##1 !r.pwm && r.dis);
   multi_cov_c: cover property ($countones(r.err) > 1 ##1 $changed(r.scroll));
   full_cov_c: cover property (log_full && log_clr);
endmodule : cfl_ctrl
`default_nettype wire

// [dv/cfl_panel_model.sv]
// Purpose: Operator panel and sequence controller facing the fault controller.
// Assumes: Pins pass a two-stage synchroniser, so each level is held four clocks.
// Notes: Pins change only by non-blocking assignment just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "cfl_params.svh"
module cfl_panel_model (
   // Clock
   input wire logic aclk,
   // Run, reset and key pins, indexed by the input bit constants
   output logic [6:0] pins
);
   // ****************************************
   // Drive tasks
   // ****************************************
   initial pins = 7'h00;
   task automatic set_run(input logic level);
      @(posedge aclk);
      pins[`CFL_IN_RUN] <= level;
      repeat (4) @(posedge aclk);
   endtask : set_run
   // The release gap is as long as the press, so the edge detector always rearms.
   task automatic press(input int k);
      @(posedge aclk);
      pins[k] <= 1'b1;
      repeat (4) @(posedge aclk);
      pins[k] <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : press
   // Run is always dropped before a reset is asked for.
   task automatic error_reset();
      set_run(1'b0);
      press(`CFL_IN_RST);
   endtask : error_reset
endmodule : cfl_panel_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the fault latch and error log controller.
// Assumes: MS_CYCLES of 4, so one ms is four clocks.
// Notes: Bus answers are sampled at the falling edge, drives land on rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "cfl_params.svh"
module tb_top
   import cfl_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   localparam int KEY_MENU = 3;
   localparam int LIMIT = 40000;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} cfl_row_t;
   logic aclk, aresetn, log_por_n, awvalid, wvalid, bready, arvalid, rready, bus_ok;
   logic awready, wready, bvalid, arready, rvalid, pwm_enable, precharge_en, discharge_en;
   logic param_edit_ok, disp_lit, irq;
   logic [7:0] awaddr, araddr, seen;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb, disp_index;
   logic [1:0] bresp, rresp, r, lits;
   logic [6:0] fault_in, pins;
   logic [2:0] disp_code;
   cfl_disp_t disp_sel;
   int fails, checks_done, n;
   int cycles = 0;
   cfl_row_t rows[14] = '{
      '{1'b0, `CFL_A_PRE_TIME, {16'h0000, `CFL_PRE_TIME_RST}}, '{1'b0, `CFL_A_IRQ_EN, 32'h0},
      '{1'b0, `CFL_A_STATUS, 32'h0}, '{1'b0, `CFL_A_IRQ_STAT, 32'h0},
      '{1'b1, `CFL_A_PRE_TIME, 32'h5}, '{1'b0, `CFL_A_PRE_TIME, 32'h5},
      '{1'b1, `CFL_A_PARAM, 32'h1234}, '{1'b0, `CFL_A_PARAM, 32'h1234},
      '{1'b1, 8'h40, 32'h0}, '{1'b0, 8'h40, 32'h0},
      '{1'b1, `CFL_A_IRQ_EN, 32'h7}, '{1'b0, `CFL_A_IRQ_EN, 32'h7},
      '{1'b1, `CFL_A_STATUS, 32'hffff}, '{1'b0, `CFL_A_STATUS, 32'h0}};
   always #5 aclk = ~aclk;
   cfl_panel_model u_panel (.aclk(aclk), .pins(pins));
   cfl_ctrl #(.MS_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .log_por_n(log_por_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .run_req(pins[`CFL_IN_RUN]), .reset_req(pins[`CFL_IN_RST]),
      .key_clear(pins[`CFL_IN_CLR]), .parameter_menu_key(pins[KEY_MENU]), .key_up(pins[`CFL_IN_UP]),
      .key_down(pins[`CFL_IN_DN]), .key_log(pins[`CFL_IN_LOG]), .fault_in(fault_in), .bus_ok(bus_ok),
      .pwm_enable(pwm_enable), .precharge_en(precharge_en), .discharge_en(discharge_en),
      .param_edit_ok(param_edit_ok), .disp_sel(disp_sel), .disp_code(disp_code),
      .disp_index(disp_index), .disp_lit(disp_lit), .irq(irq));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
      @(negedge aclk);
   endtask : cyc
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic pa, pw, ta, tw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      do begin
         @(negedge aclk);
         tb = bvalid;
         resp = bresp;
         @(posedge aclk);
      end while (!tb);
      bready <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      logic t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         t = rvalid;
         d = rdata;
         @(posedge aclk);
      end while (!t);
      rready <= 1'b0;
   endtask : bus_rd
   task automatic pulse_fault(input logic [6:0] f);
      @(posedge aclk);
      fault_in <= f;
      @(posedge aclk);
      fault_in <= 7'h00;
      cyc(3);
   endtask : pulse_fault
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   // A hang is cut short here and counted as a mismatch.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         report_and_stop();
      end
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      {aclk, aresetn, log_por_n, awvalid, wvalid, bready, arvalid, rready, bus_ok} = 9'h000;
      {awaddr, araddr, wdata, fault_in} = 55'h0;
      wstrb = 4'hf;
      fails = 0;
      checks_done = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      log_por_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            bus_wr(rows[i].a, rows[i].d, r);
            chk("bresp", 32'(r), (rows[i].a == 8'h40) ? 32'(`CFL_RESP_SLVERR) : 32'(`CFL_RESP_OKAY));
         end else begin
            bus_rd(rows[i].a, v);
            chk("rdata", v, rows[i].d);
         end
      end
      chk("rresp", 32'(rresp), 32'(`CFL_RESP_OKAY));
      $display("test registers done");
      bus_ok <= 1'b1;
      u_panel.set_run(1'b1);
      n = 0;
      while (pwm_enable !== 1'b1 && n < 400) begin
         cyc(0);
         n++;
      end
      cyc(2);
      chk("irq raised", 32'(irq), 32'h1);
      bus_wr(`CFL_A_IRQ_CLR, 32'h7, r);
      cyc(2);
      chk("irq cleared", 32'(irq), 32'h0);
      pulse_fault(7'h04);
      chk("pwm", 32'(pwm_enable), 32'h0);
      chk("discharge", 32'(discharge_en), 32'h1);
      chk("disp sel", 32'(disp_sel), 32'(DISP_ERROR));
      chk("edit ok", 32'(param_edit_ok), 32'h0);
      bus_wr(`CFL_A_PARAM, 32'h99, r);
      chk("param resp", 32'(r), 32'(`CFL_RESP_SLVERR));
      bus_rd(`CFL_A_PARAM, v);
      chk("param kept", v, 32'h1234);
      cyc(60);
      chk("no restart", 32'(pwm_enable | precharge_en), 32'h0);
      u_panel.press(`CFL_IN_CLR);
      bus_rd(`CFL_A_STATUS, v);
      chk("errors", 32'(v[7:0]), 32'h08);
      chk("log count", 32'(v[13:10]), 32'h1);
      u_panel.error_reset();
      cyc(2);
      chk("edit ok", 32'(param_edit_ok), 32'h1);
      $display("test fault while active done");
      pulse_fault(7'h06);
      seen = 8'h00;
      lits = 2'b00;
      repeat (50) begin
         cyc(100);
         seen[disp_code] = 1'b1;
         lits[disp_lit] = 1'b1;
      end
      chk("scrolled", 32'(seen), 32'h0c);
      chk("flash", 32'(lits), 32'h3);
      u_panel.press(KEY_MENU);
      cyc(1);
      chk("banner", 32'(disp_sel), 32'(DISP_BANNER));
      u_panel.press(KEY_MENU);
      u_panel.error_reset();
      for (int k = 0; k < 7; k++) begin
         pulse_fault(7'h01 << k);
      end
      u_panel.error_reset();
      pulse_fault(7'h01);
      bus_rd(`CFL_A_STATUS, v);
      chk("log full", 32'(v[13:10]), 32'(`CFL_LOG_DEPTH));
      bus_wr(`CFL_A_IRQ_EN, 32'h0, r);
      cyc(2);
      chk("irq masked", 32'(irq), 32'h0);
      bus_wr(`CFL_A_IRQ_EN, 32'h7, r);
      cyc(2);
      chk("irq pending", 32'(irq), 32'h1);
      $display("test scroll and fill done");
      u_panel.press(`CFL_IN_LOG);
      cyc(2);
      chk("log index", 32'({disp_sel, disp_index, disp_code}), {23'h0, DISP_LOG, 7'h4f});
      u_panel.press(`CFL_IN_DN);
      cyc(2);
      chk("step down", 32'({disp_index, disp_code}), 32'h46);
      u_panel.press(`CFL_IN_UP);
      cyc(2);
      chk("step up", 32'({disp_index, disp_code}), 32'h4f);
      bus_rd(`CFL_A_LOG_VIEW, v);
      chk("log view reg", v, 32'h0000004f);
      @(posedge aclk);
      aresetn <= 1'b0;
      cyc(3);
      @(posedge aclk);
      aresetn <= 1'b1;
      bus_rd(`CFL_A_STATUS, v);
      chk("log kept", 32'(v[13:10]), 32'(`CFL_LOG_DEPTH));
      u_panel.press(`CFL_IN_LOG);
      u_panel.press(`CFL_IN_CLR);
      bus_rd(`CFL_A_STATUS, v);
      chk("log erased", 32'(v[13:10]), 32'h0);
      u_panel.press(`CFL_IN_LOG);
      $display("test log view done");
      bus_wr(`CFL_A_PRE_TIME, 32'h5, r);
      bus_ok <= 1'b0;
      u_panel.set_run(1'b1);
      cyc(60);
      bus_rd(`CFL_A_STATUS, v);
      chk("precharge fault", 32'({v[0], precharge_en, pwm_enable}), 32'h4);
      u_panel.set_run(1'b0);
      u_panel.press(`CFL_IN_CLR);
      bus_rd(`CFL_A_STATUS, v);
      chk("clear key reset", 32'(v[7:0]), 32'h0);
      $display("test precharge timeout done");
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
